// ==== snd_pkg.sv ====
package snd_pkg;

    // ************************************************************
    // instruction fields (bit 0 of the field numbering is the lsb)
    // ************************************************************
    localparam int INSTR_W = 32;
    localparam int SPR_W = 10;
    localparam int PRIMARY_MSB = 31;
    localparam int PRIMARY_LSB = 26;
    localparam int FIELD_HI_MSB = 15;
    localparam int FIELD_HI_LSB = 11;
    localparam int FIELD_LO_MSB = 20;
    localparam int FIELD_LO_LSB = 16;
    localparam int XO_MSB = 10;
    localparam int XO_LSB = 1;
    localparam int XO_IGNORED_BIT = 6;

    localparam logic [5:0] OPC_EXTENDED = 6'h1F;
    localparam logic [9:0] XO_READ_SPR = 10'h153;
    localparam logic [9:0] XO_WRITE_SPR = 10'h1D3;
    localparam logic [9:0] XO_READ_TIME = 10'h173;
    localparam logic [9:0] XO_IGNORE_MASK = 10'h3DF;

    // ************************************************************
    // register numbers
    // ************************************************************
    localparam logic [9:0] NUM_FIXED_EXCEPT = 10'h001;
    localparam logic [9:0] NUM_LINK = 10'h008;
    localparam logic [9:0] NUM_COUNT = 10'h009;
    localparam logic [9:0] NUM_FAULT_LO = 10'h012;
    localparam logic [9:0] NUM_FAULT_HI = 10'h013;
    localparam logic [9:0] NUM_DECREMENTER = 10'h016;
    localparam logic [9:0] NUM_SAVE_LO = 10'h019;
    localparam logic [9:0] NUM_SAVE_HI = 10'h01B;
    localparam logic [9:0] NUM_TIME_BASE_LOWER_RD = 10'h10C;
    localparam logic [9:0] NUM_TIME_BASE_UPPER_RD = 10'h10D;
    localparam logic [9:0] NUM_SCRATCH_LO = 10'h110;
    localparam logic [9:0] NUM_SCRATCH_HI = 10'h113;
    localparam logic [9:0] NUM_EXT_ACCESS = 10'h11A;
    localparam logic [9:0] NUM_TIME_BASE_LOWER_WR = 10'h11C;
    localparam logic [9:0] NUM_TIME_BASE_UPPER_WR = 10'h11D;
    localparam logic [9:0] NUM_PROCESSOR_VERSION = 10'h11F;
    localparam logic [9:0] NUM_XLAT_A_LO = 10'h210;
    localparam logic [9:0] NUM_XLAT_A_HI = 10'h21F;
    localparam logic [9:0] NUM_XLAT_B_LO = 10'h230;
    localparam logic [9:0] NUM_XLAT_B_HI = 10'h23F;
    localparam logic [9:0] NUM_THERMAL_AUX = 10'h398;
    localparam logic [9:0] NUM_RESERVED_LO = 10'h399;
    localparam logic [9:0] NUM_RESERVED_HI = 10'h39C;
    localparam logic [9:0] NUM_USER_VIEW_LO = 10'h3A8;
    localparam logic [9:0] NUM_USER_VIEW_HI = 10'h3AE;
    localparam logic [9:0] NUM_MONITOR_LO = 10'h3B8;
    localparam logic [9:0] NUM_MONITOR_HI = 10'h3BE;
    localparam logic [9:0] NUM_HW_CFG_LO = 10'h3F0;
    localparam logic [9:0] NUM_HW_CFG_HI = 10'h3F2;
    localparam logic [9:0] NUM_DATA_BREAK = 10'h3F5;
    localparam logic [9:0] NUM_CACHE_CFG_LO = 10'h3F8;
    localparam logic [9:0] NUM_CACHE_CFG_HI = 10'h3F9;
    localparam logic [9:0] NUM_THERMAL_LO = 10'h3FB;
    localparam logic [9:0] NUM_THERMAL_HI = 10'h3FE;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [9:0] RST_SPR_NUM = 10'h000;

    // ************************************************************
    // access classes
    // ************************************************************
    typedef enum logic [2:0] {
        SND_ACC_NONE    = 3'b000,
        SND_ACC_USER_RW = 3'b001,
        SND_ACC_USER_RO = 3'b010,
        SND_ACC_SUP_RW  = 3'b011,
        SND_ACC_SUP_RO  = 3'b100,
        SND_ACC_SUP_WO  = 3'b101,
        SND_ACC_SUP_RSV = 3'b110
    } snd_acc_t;

endpackage

// ==== snd_field_split.sv ====
`timescale 1ns/1ps
`default_nettype none

module snd_field_split
    import snd_pkg::*;
(
    // instruction
    input wire logic [INSTR_W-1:0] instr,
    // decoded fields
    output logic [SPR_W-1:0] spr_num,
    output logic is_read,
    output logic is_write
);

    wire [5:0] primary = instr[PRIMARY_MSB:PRIMARY_LSB];
    wire [9:0] xo_masked = instr[XO_MSB:XO_LSB] & XO_IGNORE_MASK;
    wire is_ext = (primary == OPC_EXTENDED);

    // halves are swapped in the encoding
    assign spr_num = {instr[FIELD_HI_MSB:FIELD_HI_LSB], instr[FIELD_LO_MSB:FIELD_LO_LSB]};
    // the time read differs only in the ignored bit, so both fall here
    assign is_read = is_ext && (xo_masked == (XO_READ_SPR & XO_IGNORE_MASK));
    assign is_write = is_ext && (instr[XO_MSB:XO_LSB] == XO_WRITE_SPR);

endmodule

`default_nettype wire

// ==== snd_decoder.sv ====
`timescale 1ns/1ps
`default_nettype none

//Overview of operation
// - register number is bits 11-15 high, bits 16-20 low, halves swapped
// - time-base writes only by move-to in supervisor, numbers 284 and 285
// - user may read time-base halves by either read form, 268 and 269
// - number 287 version register is supervisor read-only; writes never alter it
// - number 920 thermal aux register is supervisor read-only; no writes
// - instruction bit 6 ignored in the read forms only; time read and register read behave alike
module snd_decoder
    import snd_pkg::*;
#(
    parameter int INSTR_WIDTH = INSTR_W
)
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // instruction stream
    input wire logic dec_valid,
    input wire logic [INSTR_WIDTH-1:0] dec_instr,
    input wire logic operating_env_level,
    // register select
    output logic out_valid_r,
    output logic [SPR_W-1:0] spr_num_r,
    output logic [2:0] acc_class_r,
    output logic rd_en_r,
    output logic wr_en_r,
    // time base select
    output logic time_base_lower_rd_r,
    output logic time_base_upper_rd_r,
    output logic time_base_lower_wr_r,
    output logic time_base_upper_wr_r,
    // exceptions
    output logic priv_fault_r,
    output logic illegal_r
);

    // ************************************************************
    // elaboration check
    // ************************************************************
    if (INSTR_WIDTH != INSTR_W)
    begin : g_width_check
        $error("snd_decoder: instruction width must be 32");
    end

    // ************************************************************
    // field extraction
    // ************************************************************
    logic [SPR_W-1:0] num;
    logic is_read;
    logic is_write;

    // halves swapped and the read forms merged in the splitter
    snd_field_split snd_field_split_i (
        .instr(dec_instr),
        .spr_num(num),
        .is_read(is_read),
        .is_write(is_write)
    );

    // ************************************************************
    // number classification
    // ************************************************************
    wire in_user_rw = (num == NUM_FIXED_EXCEPT) || (num == NUM_LINK) || (num == NUM_COUNT);

    wire in_fault = (num >= NUM_FAULT_LO) && (num <= NUM_FAULT_HI);
    wire in_save = (num >= NUM_SAVE_LO) && (num <= NUM_SAVE_HI);
    wire in_scratch = (num >= NUM_SCRATCH_LO) && (num <= NUM_SCRATCH_HI);
    wire in_xlat_a = (num >= NUM_XLAT_A_LO) && (num <= NUM_XLAT_A_HI);
    wire in_xlat_b = (num >= NUM_XLAT_B_LO) && (num <= NUM_XLAT_B_HI);
    wire in_monitor = (num >= NUM_MONITOR_LO) && (num <= NUM_MONITOR_HI);
    wire in_hw_cfg = (num >= NUM_HW_CFG_LO) && (num <= NUM_HW_CFG_HI);
    wire in_cache_cfg = (num >= NUM_CACHE_CFG_LO) && (num <= NUM_CACHE_CFG_HI);
    wire in_thermal = (num >= NUM_THERMAL_LO) && (num <= NUM_THERMAL_HI);
    wire in_sup_single = (num == NUM_DECREMENTER) || (num == NUM_EXT_ACCESS)
        || (num == NUM_DATA_BREAK);
    wire in_sup_rw = in_fault || in_save || in_scratch || in_xlat_a || in_xlat_b
        || in_monitor || in_hw_cfg || in_cache_cfg || in_thermal || in_sup_single;

    // version and thermal aux: readable in supervisor only
    wire in_sup_ro = (num == NUM_PROCESSOR_VERSION) || (num == NUM_THERMAL_AUX);

    wire is_tbl_rd = (num == NUM_TIME_BASE_LOWER_RD);
    wire is_tbu_rd = (num == NUM_TIME_BASE_UPPER_RD);
    wire in_user_view = (num >= NUM_USER_VIEW_LO) && (num <= NUM_USER_VIEW_HI);
    wire in_user_ro = is_tbl_rd || is_tbu_rd || in_user_view;

    wire is_tbl_wr = (num == NUM_TIME_BASE_LOWER_WR);
    wire is_tbu_wr = (num == NUM_TIME_BASE_UPPER_WR);
    wire in_sup_wo = is_tbl_wr || is_tbu_wr;

    // reserved block may be read but writes are dropped, so a stray
    // move-to cannot disturb contents software must preserve
    wire in_reserved = (num >= NUM_RESERVED_LO) && (num <= NUM_RESERVED_HI);

    wire known = in_user_rw || in_sup_rw || in_sup_ro || in_user_ro || in_sup_wo
        || in_reserved;
    wire need_sup = in_sup_rw || in_sup_ro || in_sup_wo || in_reserved;
    wire read_ok = in_user_rw || in_sup_rw || in_sup_ro || in_user_ro || in_reserved;
    wire write_ok = in_user_rw || in_sup_rw || in_sup_wo;

    // ************************************************************
    // grant and fault
    // ************************************************************
    wire is_move = dec_valid && (is_read || is_write);
    // privilege fault wins over direction errors
    wire priv_hit = is_move && known && need_sup && !operating_env_level;
    wire grant_rd = dec_valid && is_read && known && read_ok && !priv_hit;
    // no write to read-only numbers, time base only through move-to
    wire grant_wr = dec_valid && is_write && known && write_ok && !priv_hit;
    wire illegal_hit = is_move && !priv_hit && !grant_rd && !grant_wr;

    snd_acc_t acc_class;
    assign acc_class = in_user_rw ? SND_ACC_USER_RW :
                       in_user_ro ? SND_ACC_USER_RO :
                       in_sup_rw ? SND_ACC_SUP_RW :
                       in_sup_ro ? SND_ACC_SUP_RO :
                       in_sup_wo ? SND_ACC_SUP_WO :
                       in_reserved ? SND_ACC_SUP_RSV : SND_ACC_NONE;

    // ************************************************************
    // next values
    // ************************************************************
    wire out_valid_nxt = is_move;
    wire [SPR_W-1:0] spr_num_nxt = num;
    wire [2:0] acc_class_nxt = acc_class;
    wire rd_en_nxt = grant_rd;
    wire wr_en_nxt = grant_wr;
    wire priv_fault_nxt = priv_hit;
    wire illegal_nxt = illegal_hit;
    wire time_base_lower_rd_nxt = grant_rd && is_tbl_rd;
    wire time_base_upper_rd_nxt = grant_rd && is_tbu_rd;
    wire time_base_lower_wr_nxt = grant_wr && is_tbl_wr;
    wire time_base_upper_wr_nxt = grant_wr && is_tbu_wr;

    // ************************************************************
    // output stage
    // ************************************************************
    // one short process per output keeps each reset value beside its update
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            out_valid_r <= 1'b0;
        else
            out_valid_r <= out_valid_nxt;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            spr_num_r <= RST_SPR_NUM;
        else
            spr_num_r <= spr_num_nxt;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            acc_class_r <= SND_ACC_NONE;
        else
            acc_class_r <= acc_class_nxt;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            rd_en_r <= 1'b0;
        else
            rd_en_r <= rd_en_nxt;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            wr_en_r <= 1'b0;
        else
            wr_en_r <= wr_en_nxt;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            priv_fault_r <= 1'b0;
        else
            priv_fault_r <= priv_fault_nxt;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            illegal_r <= 1'b0;
        else
            illegal_r <= illegal_nxt;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            time_base_lower_rd_r <= 1'b0;
        else
            time_base_lower_rd_r <= time_base_lower_rd_nxt;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            time_base_upper_rd_r <= 1'b0;
        else
            time_base_upper_rd_r <= time_base_upper_rd_nxt;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            time_base_lower_wr_r <= 1'b0;
        else
            time_base_lower_wr_r <= time_base_lower_wr_nxt;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            time_base_upper_wr_r <= 1'b0;
        else
            time_base_upper_wr_r <= time_base_upper_wr_nxt;
    end

endmodule

`default_nettype wire

// ==== snd_decoder_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// decoder checks
// ************************************************************
module snd_decoder_chk
    import snd_pkg::*;
#(
    parameter int INSTR_WIDTH = INSTR_W
)
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // instruction stream
    input wire logic dec_valid,
    input wire logic [INSTR_WIDTH-1:0] dec_instr,
    input wire logic operating_env_level,
    // decoder outputs
    input wire logic out_valid_r,
    input wire logic [SPR_W-1:0] spr_num_r,
    input wire logic rd_en_r,
    input wire logic wr_en_r,
    input wire logic time_base_lower_rd_r,
    input wire logic time_base_upper_rd_r,
    input wire logic time_base_upper_wr_r,
    input wire logic time_base_lower_wr_r,
    input wire logic priv_fault_r,
    input wire logic illegal_r
);
    wire [SPR_W-1:0] num = {dec_instr[15:11], dec_instr[20:16]};
    wire is_ext = dec_valid && dec_instr[31:26] == OPC_EXTENDED;
    // read form compared with bit 6 masked off
    wire rd_op = is_ext && (dec_instr[10:1] & XO_IGNORE_MASK) == XO_READ_SPR;
    wire wr_op = is_ext && dec_instr[10:1] == XO_WRITE_SPR;
    wire sup = operating_env_level;
    wire [3:0] answers = {rd_en_r, wr_en_r, priv_fault_r, illegal_r};

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    property p_num_swap;
        rd_op || wr_op |=> spr_num_r == $past(num);
    endproperty
    property p_tb_wr;
        wr_op && sup && num == NUM_TIME_BASE_LOWER_WR |=> wr_en_r && time_base_lower_wr_r;
    endproperty
    property p_tb_wr_cause;
        time_base_upper_wr_r |-> $past(sup) && $past(wr_op)
            && spr_num_r == NUM_TIME_BASE_UPPER_WR;
    endproperty
    property p_tb_rd;
        rd_op && !sup && num == NUM_TIME_BASE_LOWER_RD |=> rd_en_r && time_base_lower_rd_r;
    endproperty
    property p_tb_rd_upper;
        rd_op && !sup && num == NUM_TIME_BASE_UPPER_RD |=> rd_en_r && time_base_upper_rd_r;
    endproperty
    property p_ro_regs;
        wr_op && sup && (num == NUM_PROCESSOR_VERSION || num == NUM_THERMAL_AUX)
            |=> illegal_r && !wr_en_r;
    endproperty
    property p_view_wr;
        wr_op && num inside {[NUM_USER_VIEW_LO:NUM_USER_VIEW_HI]} |=> illegal_r && !wr_en_r;
    endproperty
    property p_view_rd;
        rd_op && !sup && num inside {[NUM_USER_VIEW_LO:NUM_USER_VIEW_HI]} |=> rd_en_r;
    endproperty
    property p_rsv;
        wr_op && sup && num inside {[NUM_RESERVED_LO:NUM_RESERVED_HI]}
            |=> illegal_r && !wr_en_r;
    endproperty
    property p_priv;
        (rd_op || wr_op) && !sup && num == NUM_PROCESSOR_VERSION
            |=> priv_fault_r && !rd_en_r && !wr_en_r;
    endproperty
    property p_one_answer;
        (out_valid_r && $onehot(answers)) || (!out_valid_r && answers == 4'h0);
    endproperty

    a_num_swap: assert property (p_num_swap)
        else $error("register number halves not swapped");
    a_tb_wr: assert property (p_tb_wr)
        else $error("time base lower write not granted");
    a_tb_wr_cause: assert property (p_tb_wr_cause)
        else $error("time base upper write without supervisor write");
    a_tb_rd: assert property (p_tb_rd)
        else $error("user time base lower read not granted");
    a_tb_rd_upper: assert property (p_tb_rd_upper)
        else $error("user time base upper read not granted");
    a_ro_regs: assert property (p_ro_regs)
        else $error("write to read-only register not refused");
    a_view_wr: assert property (p_view_wr)
        else $error("write to monitor view not refused");
    a_view_rd: assert property (p_view_rd)
        else $error("user read of monitor view not granted");
    a_rsv: assert property (p_rsv)
        else $error("write to reserved number not refused");
    a_priv: assert property (p_priv)
        else $error("user access to supervisor number not faulted");
    a_one_answer: assert property (p_one_answer)
        else $error("not exactly one answer for an instruction");

    c_tb_wr: cover property (time_base_lower_wr_r);
    c_tb_rd: cover property (time_base_upper_rd_r);
    c_priv: cover property (priv_fault_r);
    c_view: cover property (rd_en_r && spr_num_r == NUM_USER_VIEW_LO);
endmodule

bind snd_decoder snd_decoder_chk #(
    .INSTR_WIDTH(INSTR_WIDTH)
) snd_decoder_chk_i (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .dec_valid(dec_valid),
    .dec_instr(dec_instr),
    .operating_env_level(operating_env_level),
    .out_valid_r(out_valid_r),
    .spr_num_r(spr_num_r),
    .rd_en_r(rd_en_r),
    .wr_en_r(wr_en_r),
    .time_base_lower_rd_r(time_base_lower_rd_r),
    .time_base_upper_rd_r(time_base_upper_rd_r),
    .time_base_upper_wr_r(time_base_upper_wr_r),
    .time_base_lower_wr_r(time_base_lower_wr_r),
    .priv_fault_r(priv_fault_r),
    .illegal_r(illegal_r)
);

`default_nettype wire

// ==== snd_decoder_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module snd_decoder_tb
    import snd_pkg::*;
;
    localparam logic [7:0] RD = 8'h80, WR = 8'h40, PF = 8'h20, IL = 8'h10;
    localparam logic [7:0] TLR = 8'h08, TUR = 8'h04, TLW = 8'h02, TUW = 8'h01;
    logic core_clk, rst_n, dec_valid, operating_env_level;
    logic [INSTR_W-1:0] dec_instr;
    logic out_valid_r, rd_en_r, wr_en_r, tlr, tur, tlw, tuw, priv_fault_r, illegal_r;
    logic [SPR_W-1:0] spr_num_r;
    logic [2:0] acc_class_r;
    int errors, checks;
    wire [15:0] pulses = {7'h00, out_valid_r, rd_en_r, wr_en_r, priv_fault_r, illegal_r, tlr,
        tur, tlw, tuw};

    snd_decoder snd_decoder_i (
        .core_clk(core_clk), .rst_n(rst_n), .dec_valid(dec_valid), .dec_instr(dec_instr),
        .operating_env_level(operating_env_level), .out_valid_r(out_valid_r),
        .spr_num_r(spr_num_r), .acc_class_r(acc_class_r), .rd_en_r(rd_en_r),
        .wr_en_r(wr_en_r), .time_base_lower_rd_r(tlr), .time_base_upper_rd_r(tur),
        .time_base_lower_wr_r(tlw), .time_base_upper_wr_r(tuw),
        .priv_fault_r(priv_fault_r), .illegal_r(illegal_r)
    );

    initial
    begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    // ************************************************************
    // one instruction, answer judged at the next falling edge
    // ************************************************************
    task automatic access(input logic [9:0] num, input logic [9:0] xo, input logic sup,
                          input logic [7:0] exp);
        dec_instr = {OPC_EXTENDED, 5'h03, num[4:0], num[9:5], xo, 1'b0};
        operating_env_level = sup;
        dec_valid = 1'b1;
        @(negedge core_clk);
        check({6'h00, spr_num_r}, {6'h00, num});
        check(pulses, {7'h00, exp != 8'h00, exp});
    endtask

    task automatic idle();
        dec_valid = 1'b0;
        @(negedge core_clk);
    endtask

    task automatic t_swap();
        access(NUM_LINK, XO_READ_SPR, 1'b0, RD);
        access(NUM_FIXED_EXCEPT, XO_WRITE_SPR, 1'b0, WR);
        access(NUM_LINK, 10'h000, 1'b0, 8'h00);
        access(10'h000, XO_READ_SPR, 1'b1, IL);
        idle();
        // a move word with the strobe low, then the strobe with a foreign opcode
        dec_instr = {OPC_EXTENDED, 5'h03, NUM_LINK[4:0], NUM_LINK[9:5], XO_READ_SPR, 1'b0};
        @(negedge core_clk);
        check(pulses, 16'h0000);
        dec_instr[31:26] = 6'h1E;
        dec_valid = 1'b1;
        @(negedge core_clk);
        check(pulses, 16'h0000);
        idle();
    endtask

    task automatic t_time_base();
        access(NUM_TIME_BASE_LOWER_WR, XO_WRITE_SPR, 1'b1, WR | TLW);
        check({13'h0000, acc_class_r}, {13'h0000, SND_ACC_SUP_WO});
        access(NUM_TIME_BASE_UPPER_WR, XO_WRITE_SPR, 1'b1, WR | TUW);
        access(NUM_TIME_BASE_UPPER_WR, XO_WRITE_SPR, 1'b0, PF);
        access(NUM_TIME_BASE_LOWER_WR, XO_READ_SPR, 1'b1, IL);
        access(NUM_TIME_BASE_LOWER_RD, XO_READ_SPR, 1'b0, RD | TLR);
        check({13'h0000, acc_class_r}, {13'h0000, SND_ACC_USER_RO});
        access(NUM_TIME_BASE_UPPER_RD, XO_READ_TIME, 1'b0, RD | TUR);
        access(NUM_TIME_BASE_LOWER_RD, XO_WRITE_SPR, 1'b1, IL);
        access(NUM_COUNT, XO_READ_TIME, 1'b0, RD);
        idle();
    endtask

    task automatic t_read_only();
        access(NUM_PROCESSOR_VERSION, XO_READ_SPR, 1'b1, RD);
        check({13'h0000, acc_class_r}, {13'h0000, SND_ACC_SUP_RO});
        access(NUM_PROCESSOR_VERSION, XO_WRITE_SPR, 1'b1, IL);
        access(NUM_PROCESSOR_VERSION, XO_READ_TIME, 1'b0, PF);
        access(NUM_THERMAL_AUX, XO_READ_SPR, 1'b1, RD);
        access(NUM_THERMAL_AUX, XO_WRITE_SPR, 1'b1, IL);
        access(NUM_THERMAL_AUX, XO_READ_SPR, 1'b0, PF);
        access(NUM_SAVE_LO, XO_WRITE_SPR, 1'b0, PF);
        idle();
    endtask

    task automatic t_views();
        for (logic [9:0] n = NUM_USER_VIEW_LO; n <= NUM_USER_VIEW_HI; n++)
        begin
            access(n, XO_READ_SPR, 1'b0, RD);
            access(n, XO_WRITE_SPR, 1'b0, IL);
        end
        check({13'h0000, acc_class_r}, {13'h0000, SND_ACC_USER_RO});
        idle();
    endtask

    task automatic t_reserved();
        for (logic [9:0] n = NUM_RESERVED_LO; n <= NUM_RESERVED_HI; n++)
        begin
            access(n, XO_WRITE_SPR, 1'b1, IL);
            access(n, XO_READ_SPR, 1'b0, PF);
        end
        check({13'h0000, acc_class_r}, {13'h0000, SND_ACC_SUP_RSV});
        idle();
    endtask

    // reset dropped while an instruction is presented, then released
    task automatic t_reset_mid();
        access(NUM_TIME_BASE_LOWER_WR, XO_WRITE_SPR, 1'b1, WR | TLW);
        rst_n = 1'b0;
        #1;
        check(pulses, 16'h0000);
        @(negedge core_clk);
        check({6'h00, spr_num_r}, {6'h00, RST_SPR_NUM});
        rst_n = 1'b1;
        access(NUM_TIME_BASE_LOWER_WR, XO_WRITE_SPR, 1'b1, WR | TLW);
        idle();
    endtask

    task automatic complete_run();
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // hang guard well beyond the fewer than a hundred cycles of the run
    initial
    begin
        repeat (2000) @(posedge core_clk);
        errors++;
        complete_run();
    end

    initial
    begin
        errors = 0;
        checks = 0;
        rst_n = 1'b0;
        dec_valid = 1'b0;
        dec_instr = 32'h0000_0000;
        operating_env_level = 1'b0;
        repeat (10) @(posedge core_clk);
        @(negedge core_clk);
        check(pulses, 16'h0000);
        rst_n = 1'b1;
        t_swap();
        t_time_base();
        t_read_only();
        t_views();
        t_reserved();
        t_reset_mid();
        complete_run();
    end
endmodule

`default_nettype wire
